// >>> core/amd_decoder.sv
`timescale 1ns/1ps
`include "amd_consts.svh"
// Behaviour
// RQ1: seventeen addressing modes in nine groups are decoded from a mode input.
// RQ2: inherent mode fetches no operand byte; instruction length is one byte.
// RQ3: immediate mode takes one byte following opcode as operand value.
// RQ4: short forms stay in page zero, except short indexed which reaches 1FE; long forms reach full 64K.
// RQ5: short direct uses one fetched byte as page-zero address.
// RQ6: long direct uses two fetched bytes as a 16-bit address.
// RQ7: indexed address is unsigned sum of selected index and offset.
// RQ8: no-offset indexed fetches nothing, address is index value alone.
// RQ9: short indexed adds one offset byte, reaching up to 1FE.
// RQ10: long indexed adds a 16-bit offset to the index register.
// RQ11: indirect modes read a pointer from memory before operand access.
// RQ12: relative base is address of next instruction; reach -128..+127.
// RQ13: read-modify-write instructions are refused in long addressing forms.
// RQ14: three prefix bytes select Y index, indirect, or Y indirect forms.
// RQ15: short indirect reads a one-byte pointer, operand within page zero.
// RQ16: relative target adds an 8-bit signed offset to program counter.
// RQ17: long values take first fetched byte as high, second as low.
// RQ18: X index by default; a prefix byte counts in instruction length.
module amd_decoder (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // instruction request, valid for one cycle
  input wire logic i_start,
  input wire logic [7:0] i_prefix,
  input wire logic i_has_prefix,
  input wire amd_pkg::amd_mode_e i_mode,
  input wire logic i_rmw,
  input wire logic [15:0] i_pc_next,
  input wire logic [7:0] i_x,
  input wire logic [7:0] i_y,
  // memory read port
  output logic o_rd,
  output logic [15:0] o_rd_addr,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_data,
  // result
  output logic o_done,
  output logic [15:0] o_ea,
  output logic [7:0] o_imm,
  output logic [2:0] o_len,
  output logic o_illegal,
  output logic o_busy
);
  amd_pkg::amd_state_e state_reg, state_next;
  amd_pkg::amd_mode_e mode_reg, mode_next;
  logic [15:0] addr_reg, addr_next;
  logic [15:0] pc_reg, pc_next;
  logic [15:0] val_reg, val_next;
  logic [15:0] ea_reg, ea_next;
  logic [7:0] imm_reg, imm_next;
  logic [7:0] idx_reg, idx_next;
  logic [2:0] len_reg, len_next;
  logic [1:0] cnt_reg, cnt_next, need_reg, need_next;
  logic ill_reg, ill_next;
  logic [2:0] ops;
  logic [1:0] need;
  logic ind_pre, y_pre;
  logic long_form;
  amd_pkg::amd_mode_e eff_mode;
  // prefix decode
  always_comb
  begin
    // RQ14 prefix selection
    y_pre = i_has_prefix && (i_prefix == `AMD_PRE_Y || i_prefix == `AMD_PRE_YIND);
    ind_pre = i_has_prefix && (i_prefix == `AMD_PRE_IND || i_prefix == `AMD_PRE_YIND);
    eff_mode = i_mode;
    if (ind_pre)
    begin
      unique case (i_mode)
        amd_pkg::AMD_DIR_S: eff_mode = amd_pkg::AMD_IND_S;
        amd_pkg::AMD_DIR_L: eff_mode = amd_pkg::AMD_IND_L;
        amd_pkg::AMD_IDX_S: eff_mode = amd_pkg::AMD_INDX_S;
        amd_pkg::AMD_IDX_L: eff_mode = amd_pkg::AMD_INDX_L;
        amd_pkg::AMD_REL_D: eff_mode = amd_pkg::AMD_REL_I;
        amd_pkg::AMD_BIT_D: eff_mode = amd_pkg::AMD_BIT_I;
        amd_pkg::AMD_BITR_D: eff_mode = amd_pkg::AMD_BITR_I;
        default: eff_mode = i_mode;
      endcase
    end
  end
  // RQ1 operand bytes per mode
  always_comb
  begin
    ops = 3'h1;
    need = 2'h1;
    long_form = 1'b0;
    unique case (eff_mode)
      // RQ2 RQ8 no operand byte
      amd_pkg::AMD_INH, amd_pkg::AMD_IDX_N:
      begin
        ops = 3'h0;
        need = 2'h0;
      end
      amd_pkg::AMD_DIR_L, amd_pkg::AMD_IDX_L:
      begin
        ops = 3'h2;
        need = 2'h2;
        long_form = 1'b1;
      end
      amd_pkg::AMD_IND_L, amd_pkg::AMD_INDX_L: long_form = 1'b1;
      amd_pkg::AMD_BITR_D, amd_pkg::AMD_BITR_I: ops = 3'h2;
      default: ops = 3'h1;
    endcase
  end
  always_comb
  begin
    state_next = state_reg;
    mode_next = mode_reg;
    addr_next = addr_reg;
    pc_next = pc_reg;
    val_next = val_reg;
    ea_next = ea_reg;
    imm_next = imm_reg;
    idx_next = idx_reg;
    len_next = len_reg;
    cnt_next = cnt_reg;
    need_next = need_reg;
    ill_next = ill_reg;
    unique case (state_reg)
      amd_pkg::AMD_IDLE:
      begin
        if (i_start)
        begin
          mode_next = eff_mode;
          // RQ18 default X, prefix counted
          idx_next = y_pre ? i_y : i_x;
          len_next = 3'h1 + ops + {2'h0, i_has_prefix};
          // RQ13 rmw long refused
          ill_next = i_rmw && long_form;
          addr_next = i_pc_next - {13'h0, ops};
          pc_next = i_pc_next;
          val_next = 16'h0000;
          cnt_next = 2'h0;
          need_next = need;
          state_next = (need == 2'h0) ? amd_pkg::AMD_DONE : amd_pkg::AMD_OPB;
        end
      end
      amd_pkg::AMD_OPB:
      begin
        if (i_rd_valid)
        begin
          // RQ17 high byte first
          val_next = {val_reg[7:0], i_rd_data};
          addr_next = addr_reg + 16'h0001;
          cnt_next = cnt_reg + 2'h1;
          if (cnt_reg + 2'h1 == need_reg)
          begin
            unique case (mode_reg)
              amd_pkg::AMD_IND_S, amd_pkg::AMD_IND_L, amd_pkg::AMD_INDX_S,
              amd_pkg::AMD_INDX_L, amd_pkg::AMD_REL_I, amd_pkg::AMD_BIT_I,
              amd_pkg::AMD_BITR_I:
              begin
                // RQ11 pointer fetch next
                addr_next = {8'h00, i_rd_data};
                val_next = 16'h0000;
                state_next = amd_pkg::AMD_PTR;
              end
              default: state_next = amd_pkg::AMD_DONE;
            endcase
          end
        end
      end
      amd_pkg::AMD_PTR:
      begin
        if (i_rd_valid)
        begin
          val_next = {8'h00, i_rd_data};
          addr_next = addr_reg + 16'h0001;
          // RQ15 byte pointer for short forms, two-byte pointer for long forms
          state_next = (mode_reg == amd_pkg::AMD_IND_L || mode_reg == amd_pkg::AMD_INDX_L)
            ? amd_pkg::AMD_PTR2 : amd_pkg::AMD_DONE;
        end
      end
      amd_pkg::AMD_PTR2:
      begin
        if (i_rd_valid)
        begin
          val_next = {val_reg[7:0], i_rd_data};
          state_next = amd_pkg::AMD_DONE;
        end
      end
      amd_pkg::AMD_DONE: state_next = amd_pkg::AMD_IDLE;
    endcase
    if (state_reg != amd_pkg::AMD_IDLE && state_next == amd_pkg::AMD_DONE)
    begin
      // RQ3 operand value kept
      imm_next = val_next[7:0];
      unique case (mode_reg)
        // RQ4 RQ5 page zero short
        amd_pkg::AMD_DIR_S, amd_pkg::AMD_IND_S, amd_pkg::AMD_BIT_D, amd_pkg::AMD_BIT_I,
        amd_pkg::AMD_BITR_D, amd_pkg::AMD_BITR_I: ea_next = {8'h00, val_next[7:0]};
        // RQ6 long direct
        amd_pkg::AMD_DIR_L, amd_pkg::AMD_IND_L: ea_next = val_next;
        // RQ7 RQ9 RQ10 unsigned index sum
        amd_pkg::AMD_IDX_S, amd_pkg::AMD_INDX_S: ea_next = {8'h00, val_next[7:0]} + {8'h00, idx_reg};
        amd_pkg::AMD_IDX_L, amd_pkg::AMD_INDX_L: ea_next = val_next + {8'h00, idx_reg};
        // RQ12 RQ16 signed relative
        amd_pkg::AMD_REL_D, amd_pkg::AMD_REL_I:
          ea_next = pc_reg + {{8{val_next[7]}}, val_next[7:0]};
        default: ea_next = `AMD_RST_ADDR;
      endcase
    end
    else if (state_reg == amd_pkg::AMD_IDLE && state_next == amd_pkg::AMD_DONE)
    begin
      // RQ8 index alone
      ea_next = (mode_next == amd_pkg::AMD_IDX_N) ? {8'h00, idx_next} : `AMD_RST_ADDR;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_reg <= amd_pkg::AMD_IDLE;
      mode_reg <= amd_pkg::AMD_INH;
      addr_reg <= `AMD_RST_ADDR;
      pc_reg <= `AMD_RST_ADDR;
      val_reg <= `AMD_RST_ADDR;
      ea_reg <= `AMD_RST_ADDR;
      imm_reg <= 8'h00;
      idx_reg <= 8'h00;
      len_reg <= `AMD_RST_LEN;
      cnt_reg <= 2'h0;
      need_reg <= 2'h0;
      ill_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      addr_reg <= addr_next;
      pc_reg <= pc_next;
      val_reg <= val_next;
      ea_reg <= ea_next;
      imm_reg <= imm_next;
      idx_reg <= idx_next;
      len_reg <= len_next;
      cnt_reg <= cnt_next;
      need_reg <= need_next;
      ill_reg <= ill_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  assign o_rd = (state_reg == amd_pkg::AMD_OPB) || (state_reg == amd_pkg::AMD_PTR)
    || (state_reg == amd_pkg::AMD_PTR2);
  assign o_rd_addr = addr_reg;
  assign o_done = (state_reg == amd_pkg::AMD_DONE);
  assign o_ea = ea_reg;
  assign o_imm = imm_reg;
  assign o_len = len_reg;
  assign o_illegal = ill_reg;
  assign o_busy = (state_reg != amd_pkg::AMD_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  sequence start_inh_s;
    i_start && !o_busy && (eff_mode == amd_pkg::AMD_INH);
  endsequence
  sequence done_now_s;
    o_done && !o_rd;
  endsequence
  inherent_no_fetch_a: // RQ2
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      start_inh_s |=> done_now_s)
    else $error("inherent mode fetched an operand");
  inherent_length_a: // RQ18
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      start_inh_s |=> (o_len == 3'h1 + {2'h0, $past(i_has_prefix)}))
    else $error("inherent length wrong");
  short_page_zero_a: // RQ4
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      (o_done && mode_reg == amd_pkg::AMD_DIR_S) |-> (o_ea <= `AMD_PAGE0_TOP))
    else $error("short direct left page zero");
  short_index_reach_a: // RQ9
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      (o_done && mode_reg == amd_pkg::AMD_IDX_S) |-> (o_ea <= 16'h01fe))
    else $error("short indexed out of reach");
  rmw_long_refused_a: // RQ13
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_start && !o_busy && i_rmw && long_form) |=> o_illegal)
    else $error("long rmw not flagged");
  rel_reach_a: // RQ12
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      (o_done && mode_reg == amd_pkg::AMD_REL_D) |->
        ((o_ea - pc_reg) <= 16'h007f || (pc_reg - o_ea) <= 16'h0080))
    else $error("relative target out of range");
  no_offset_index_a: // RQ8
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_start && !o_busy && eff_mode == amd_pkg::AMD_IDX_N && !y_pre) |=>
        (o_done && o_ea == {8'h00, $past(i_x)}))
    else $error("no-offset indexed address wrong");
  done_one_cycle_a: // RQ1
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_done |=> !o_done)
    else $error("done held more than one cycle");
endmodule

// >>> core/amd_consts.svh
`ifndef AMD_CONSTS_SVH
`define AMD_CONSTS_SVH
// prefix byte codes
`define AMD_PRE_Y 8'h90
`define AMD_PRE_IND 8'h92
`define AMD_PRE_YIND 8'h91
// page zero upper bound
`define AMD_PAGE0_TOP 16'h00ff
// reset values
`define AMD_RST_ADDR 16'h0000
`define AMD_RST_LEN 3'h0
`endif

// >>> core/amd_pkg.sv
package amd_pkg;
  // the seventeen addressing modes, grouped by first word
  typedef enum logic [4:0] {
    AMD_INH, AMD_IMM, AMD_DIR_S, AMD_DIR_L, AMD_IDX_N, AMD_IDX_S, AMD_IDX_L,
    AMD_IND_S, AMD_IND_L, AMD_INDX_S, AMD_INDX_L, AMD_REL_D, AMD_REL_I,
    AMD_BIT_D, AMD_BIT_I, AMD_BITR_D, AMD_BITR_I
  } amd_mode_e;
  typedef enum logic [4:0] {
    AMD_IDLE = 5'h01,
    AMD_OPB = 5'h02,
    AMD_PTR = 5'h04,
    AMD_PTR2 = 5'h08,
    AMD_DONE = 5'h10
  } amd_state_e;
endpackage

// >>> testbench/amd_mem_model.sv
`timescale 1ns/1ps
module amd_mem_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // read port
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic i_slow,
  output logic o_valid,
  output logic [7:0] o_data
);
  logic [1:0] wait_reg;
  function automatic logic [7:0] mem_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  // slow mode stalls three cycles; idle data toggles every cycle
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_valid <= 1'b0;
      o_data <= 8'h00;
      wait_reg <= 2'h0;
    end
    else if (i_rd && !o_valid && (!i_slow || wait_reg == 2'h3))
    begin
      o_valid <= 1'b1;
      o_data <= mem_val(i_addr);
      wait_reg <= 2'h0;
    end
    else
    begin
      o_valid <= 1'b0;
      o_data <= ~o_data;
      wait_reg <= wait_reg + (i_rd ? 2'h1 : 2'h0);
    end
  end
endmodule

// >>> testbench/cpu_addressing_mode_decoder_bench.sv
`timescale 1ns/1ps
module cpu_addressing_mode_decoder_bench;
  logic clk = 1'b0, rstn = 1'b0, start = 1'b0, has_pre = 1'b0, rmw = 1'b0;
  logic slow = 1'b0, poke = 1'b0, rd, valid, done, illegal, busy;
  logic [7:0] pre = 8'h00, x = 8'h00, y = 8'h00, rd_data, imm, p;
  logic [15:0] pc = 16'h0000, rd_addr, ea;
  logic [2:0] len;
  amd_pkg::amd_mode_e mode = amd_pkg::AMD_INH;
  int err_count = 0, total_checks = 0;
  always #2.5 clk = ~clk;
  amd_decoder amd_decoder_inst (
    .i_clk(clk), .i_rstn(rstn), .i_start(start), .i_prefix(pre), .i_has_prefix(has_pre),
    .i_mode(mode), .i_rmw(rmw), .i_pc_next(pc), .i_x(x), .i_y(y), .o_rd(rd),
    .o_rd_addr(rd_addr), .i_rd_valid(valid), .i_rd_data(rd_data), .o_done(done),
    .o_ea(ea), .o_imm(imm), .o_len(len), .o_illegal(illegal), .o_busy(busy)
  );
  amd_mem_model amd_mem_model_inst (
    .i_clk(clk), .i_rstn(rstn), .i_rd(rd), .i_addr(rd_addr), .i_slow(slow),
    .o_valid(valid), .o_data(rd_data)
  );
  function automatic logic [7:0] m(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  function automatic logic [15:0] rel(input logic [15:0] b, input logic [7:0] o);
    return b + {{8{o[7]}}, o};
  endfunction
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(input amd_pkg::amd_mode_e md, input logic [7:0] pb, input logic [15:0] a);
    int n;
    @(negedge clk);
    mode = md;
    pre = pb;
    has_pre = (pb != 8'h00);
    pc = a;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60)
    begin
      @(negedge clk);
      n++;
      start = poke && n == 2;
      if (start)
        mode = amd_pkg::AMD_INH;
    end
    cmp_byte({7'h00, done}, 8'h01);
  endtask
  task automatic t_simple;
    run(amd_pkg::AMD_INH, 8'h00, 16'h1234);
    cmp_byte({5'h00, len}, 8'h01);
    run(amd_pkg::AMD_IMM, 8'h00, 16'h1000);
    cmp_byte(imm, m(16'h0fff));
    cmp_byte({5'h00, len}, 8'h02);
  endtask
  task automatic t_direct;
    run(amd_pkg::AMD_DIR_S, 8'h00, 16'h2002);
    cmp_word(ea, {8'h00, m(16'h2001)});
    slow = 1'b1;
    poke = 1'b1;
    run(amd_pkg::AMD_DIR_L, 8'h00, 16'h3003);
    poke = 1'b0;
    slow = 1'b0;
    cmp_word(ea, {m(16'h3001), m(16'h3002)});
    cmp_byte({5'h00, len}, 8'h03);
  endtask
  task automatic t_indexed;
    x = 8'hff;
    y = 8'hc7;
    run(amd_pkg::AMD_IDX_N, 8'h00, 16'h1100);
    cmp_word(ea, 16'h00ff);
    cmp_byte({5'h00, len}, 8'h01);
    run(amd_pkg::AMD_IDX_N, 8'h90, 16'h1200);
    cmp_word(ea, 16'h00c7);
    cmp_byte({5'h00, len}, 8'h02);
    run(amd_pkg::AMD_IDX_S, 8'h00, 16'h4084);
    cmp_word(ea, 16'h00ff + {8'h00, m(16'h4083)});
    x = 8'h10;
    run(amd_pkg::AMD_IDX_L, 8'h00, 16'h5005);
    cmp_word(ea, {m(16'h5003), m(16'h5004)} + 16'h0010);
  endtask
  task automatic t_indirect;
    x = 8'h20;
    y = 8'h33;
    run(amd_pkg::AMD_DIR_S, 8'h92, 16'h6002);
    cmp_word(ea, {8'h00, m({8'h00, m(16'h6001)})});
    cmp_byte({5'h00, len}, 8'h03);
    run(amd_pkg::AMD_DIR_L, 8'h92, 16'h7002);
    p = m(16'h7001);
    cmp_word(ea, {m({8'h00, p}), m({8'h00, p} + 16'h0001)});
    run(amd_pkg::AMD_IDX_S, 8'h92, 16'h8002);
    cmp_word(ea, {8'h00, m({8'h00, m(16'h8001)})} + 16'h0020);
    run(amd_pkg::AMD_IDX_S, 8'h91, 16'h8102);
    cmp_word(ea, {8'h00, m({8'h00, m(16'h8101)})} + 16'h0033);
    run(amd_pkg::AMD_IDX_L, 8'h92, 16'h8202);
    p = m(16'h8201);
    cmp_word(ea, {m({8'h00, p}), m({8'h00, p} + 16'h0001)} + 16'h0020);
  endtask
  task automatic t_relative;
    run(amd_pkg::AMD_REL_D, 8'h00, 16'h9002);
    cmp_word(ea, rel(16'h9002, m(16'h9001)));
    run(amd_pkg::AMD_REL_D, 8'h92, 16'ha003);
    cmp_word(ea, rel(16'ha003, m({8'h00, m(16'ha002)})));
    cmp_byte({5'h00, len}, 8'h03);
  endtask
  task automatic t_bit;
    run(amd_pkg::AMD_BIT_D, 8'h00, 16'hb002);
    cmp_word(ea, {8'h00, m(16'hb001)});
    run(amd_pkg::AMD_BIT_D, 8'h92, 16'hb102);
    cmp_word(ea, {8'h00, m({8'h00, m(16'hb101)})});
    run(amd_pkg::AMD_BITR_D, 8'h00, 16'hc003);
    cmp_word(ea, {8'h00, m(16'hc001)});
    cmp_byte({5'h00, len}, 8'h03);
    run(amd_pkg::AMD_BITR_D, 8'h92, 16'hd004);
    cmp_word(ea, {8'h00, m({8'h00, m(16'hd002)})});
    cmp_byte({5'h00, len}, 8'h04);
  endtask
  task automatic t_rmw;
    rmw = 1'b1;
    run(amd_pkg::AMD_DIR_L, 8'h00, 16'he003);
    cmp_byte({7'h00, illegal}, 8'h01);
    run(amd_pkg::AMD_DIR_S, 8'h00, 16'he102);
    rmw = 1'b0;
    cmp_byte({7'h00, illegal}, 8'h00);
  endtask
  task automatic t_reset;
    slow = 1'b1;
    @(negedge clk);
    mode = amd_pkg::AMD_DIR_L;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    cmp_word(ea, 16'h0000);
    cmp_byte({4'h0, busy, done, rd, illegal}, 8'h00);
    rstn = 1'b1;
    slow = 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    t_simple();
    t_direct();
    t_indexed();
    t_indirect();
    t_relative();
    t_bit();
    t_rmw();
    t_reset();
    t_simple();
    wrap_up();
  end
  initial
  begin
    #25000;
    err_count++;
    wrap_up();
  end
endmodule
